// file: hw/ldisc_pkg.sv
package ldisc_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_STATUS_VALUE = 8'h00;
    localparam logic [7:0] REG_CONFIG_VIEW  = 8'h04;
    localparam logic [7:0] REG_LINK_VIEW    = 8'h08;
    localparam logic [7:0] REG_RAM_COUNT    = 8'h0c;
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    // Fixed upper part of the slave address
    localparam logic [4:0] SLAVE_ADDR_HI    = 5'h0f;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    // Command pages
    localparam logic [2:0] PAGE_RESET       = 3'h0;
    localparam logic [2:0] PAGE_SPECIAL     = 3'h3;
    localparam logic [2:0] PAGE_HVGEN       = 3'h5;
    localparam logic [2:0] PAGE_DISPLAY     = 3'h6;
    // Command patterns: mask and value
    localparam logic [7:0] PAGE_MASK = 8'hf8, PAGE_VAL = 8'h08;
    localparam logic [7:0] FSET_MASK = 8'hf9, FSET_VAL = 8'h10;
    localparam logic [7:0] EXTD_MASK = 8'hf9, EXTD_VAL = 8'h08;
    localparam logic [7:0] SIZE_MASK = 8'hfb, SIZE_VAL = 8'h20;
    localparam logic [7:0] HVC_MASK  = 8'hfc, HVC_VAL  = 8'h04;
    localparam logic [7:0] TMP_MASK  = 8'hfe, TMP_VAL  = 8'h20;
    localparam logic [7:0] STC_MASK  = 8'hfc, STC_VAL  = 8'h04;
    localparam logic [7:0] OSC_MASK  = 8'hfd, OSC_VAL  = 8'h08;
    localparam logic [7:0] COG_MASK  = 8'he7, COG_VAL  = 8'h40;
    // Control byte fields
    localparam int CTRL_CO_BIT = 7;
    localparam int CTRL_DC_BIT = 6;

    typedef struct packed {
        logic power_down_bit;
        logic vertical_entry_bit;
        logic charge_pump_enable;
        logic lcd_voltage_range_select;
        logic temp_measure_start;
        logic column_mirror;
        logic row_mirror;
        logic top_row_swap;
        logic bottom_row_swap;
        logic ext_clock_select;
        logic supply_bypass_mode;
        logic display_blank_mode;
        logic bias_current_high;
    } ldisc_cfg_t;

    // Chip starts powered down, everything else inactive
    localparam ldisc_cfg_t CFG_RESET = 13'h1000;

    typedef enum logic [2:0] {
        MODE_PWRDN  = 3'b000,
        MODE_BLANK  = 3'b001,
        MODE_INTGEN = 3'b010,
        MODE_VDDSUP = 3'b011,
        MODE_EXTSUP = 3'b100
    } ldisc_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b010,
        ST_CTRL  = 3'b011,
        ST_DATA  = 3'b100,
        ST_TX    = 3'b101,
        ST_TXACK = 3'b110,
        ST_WAIT  = 3'b111
    } ldisc_state_t;
endpackage : ldisc_pkg

// file: hw/ldisc_top.sv
`timescale 1ns/1ps
// Functional notes
// - Power-down bit overrides all other mode bits
// - Blank mode: analog off except temperature
// - Charge pump on: internal LCD generator
// - Bypass mode: logic supply drives LCD
// - Otherwise external LCD supply input used
// - Clock select: internal oscillator or pad
// - Bias current high or low selection
// - Single-bit settings active high
// - SDA stable while SCL high
// - START and STOP detected, idle high
// - Slave drives acknowledge low after bytes
// - Master NACK ends read, SDA released
// - Address 01111 plus two strap bits
// - Ignore other addresses, acknowledge own
// - First write byte is control byte
// - Read shifts status out on data-out line
// - Continuation zero: only data bytes follow
// - Continuation one: one data, then control
// - Command byte configures, reads give status
// - Data bytes go to display RAM
// - Function set carries power-down, entry direction
// - State control carries blank and bypass
module ldisc_top
    import ldisc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             serial_data_out_line_out,
    output logic             serial_data_out_line_oe,
    input  wire logic        address_strap_0,
    input  wire logic        address_strap_1,
    output ldisc_cfg_t       cfg,
    output ldisc_mode_t      op_mode,
    output logic             int_osc_enable,
    output logic             ram_wr,
    output logic      [7:0]  ram_wr_data
);
    logic [2:0]   scl_sync_reg, sda_sync_reg;
    logic [1:0]   strap_sync1_reg, strap_sync2_reg, strap_reg;
    logic         scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
    ldisc_state_t state_reg, ret_reg;
    logic [3:0]   bitcnt_reg;
    logic [7:0]   shift_reg, tx_reg, status_reg, last_cmd_reg;
    logic         co_reg, dc_reg, serial_data_out_line_oe_reg, ack_oe_reg;
    logic [2:0]   page_reg;
    ldisc_cfg_t   cfg_reg;
    ldisc_mode_t  mode_reg;
    logic         osc_en_reg, ram_wr_reg;
    logic [7:0]   ram_data_reg;
    logic [15:0]  ram_cnt_reg;
    logic         byte_end, addr_match, cmd_evt, ram_evt;
    logic         ap_valid_reg, ap_write_reg;
    logic [7:0]   ap_addr_reg;
    logic [31:0]  hrdata_reg, rd_mux;
    logic         ahb_take;

    // Two-stage synchronisers plus one delay stage for edges
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
        end
    end

    assign scl_s    = scl_sync_reg[1];
    assign sda_s    = sda_sync_reg[1];
    assign scl_rise = scl_s && !scl_sync_reg[2];
    assign scl_fall = !scl_s && scl_sync_reg[2];
    // Data edges while clock high are conditions, not data
    assign start_c  = scl_s && scl_sync_reg[2] && !sda_s && sda_sync_reg[2];
    assign stop_c   = scl_s && scl_sync_reg[2] && sda_s && !sda_sync_reg[2];

    // Strap pins synchronised, latched while the bus is idle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_sync1_reg <= 2'h0;
            strap_sync2_reg <= 2'h0;
            strap_reg       <= 2'h0;
        end else begin
            strap_sync1_reg <= {address_strap_1, address_strap_0};
            strap_sync2_reg <= strap_sync1_reg;
            if (state_reg == ST_IDLE) begin
                strap_reg <= strap_sync2_reg;
            end
        end
    end

    // Byte boundary: falling clock after eight sampled bits
    assign byte_end   = scl_fall && bitcnt_reg == BYTE_BITS;
    assign addr_match = shift_reg[7:1] == {SLAVE_ADDR_HI, strap_reg};
    assign cmd_evt    = state_reg == ST_DATA && byte_end && !dc_reg;
    assign ram_evt    = state_reg == ST_DATA && byte_end && dc_reg;

    // Serial protocol engine
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= ST_IDLE;
            ret_reg       <= ST_IDLE;
            bitcnt_reg    <= 4'h0;
            shift_reg     <= 8'h00;
            tx_reg        <= 8'h00;
            co_reg        <= 1'b0;
            dc_reg        <= 1'b0;
            ack_oe_reg    <= 1'b0;
            serial_data_out_line_oe_reg <= 1'b0;
        end else if (start_c) begin
            state_reg     <= ST_ADDR;
            bitcnt_reg    <= 4'h0;
            ack_oe_reg    <= 1'b0;
            serial_data_out_line_oe_reg <= 1'b0;
        end else if (stop_c) begin
            state_reg     <= ST_IDLE;
            ack_oe_reg    <= 1'b0;
            serial_data_out_line_oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_WAIT: begin
                    bitcnt_reg <= 4'h0;
                end
                ST_ADDR, ST_CTRL, ST_DATA: begin
                    if (scl_rise && bitcnt_reg != BYTE_BITS) begin
                        shift_reg  <= {shift_reg[6:0], sda_s};
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (byte_end) begin
                        bitcnt_reg <= 4'h0;
                        ack_oe_reg <= 1'b1;
                        state_reg  <= ST_ACK;
                        if (state_reg == ST_ADDR) begin
                            if (!addr_match) begin
                                ack_oe_reg <= 1'b0;
                                state_reg  <= ST_WAIT;
                            end
                            ret_reg <= shift_reg[0] ? ST_TX : ST_CTRL;
                        end else if (state_reg == ST_CTRL) begin
                            co_reg  <= shift_reg[CTRL_CO_BIT];
                            dc_reg  <= shift_reg[CTRL_DC_BIT];
                            ret_reg <= ST_DATA;
                        end else begin
                            ret_reg <= co_reg ? ST_CTRL : ST_DATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_oe_reg <= 1'b0;
                        state_reg  <= ret_reg;
                        if (ret_reg == ST_TX) begin
                            serial_data_out_line_oe_reg <= !status_reg[7];
                            tx_reg        <= {status_reg[6:0], 1'b0};
                            bitcnt_reg    <= 4'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_reg == BYTE_BITS) begin
                            serial_data_out_line_oe_reg <= 1'b0;
                            state_reg     <= ST_TXACK;
                        end else begin
                            serial_data_out_line_oe_reg <= !tx_reg[7];
                            tx_reg        <= {tx_reg[6:0], 1'b0};
                            bitcnt_reg    <= bitcnt_reg + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_reg <= ST_WAIT;
                        end else begin
                            state_reg  <= ST_TX;
                            tx_reg     <= status_reg;
                            bitcnt_reg <= 4'h0;
                        end
                    end
                end
            endcase
        end
    end

    // Command decoder, page-specific patterns before common ones
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg      <= CFG_RESET;
            page_reg     <= PAGE_RESET;
            last_cmd_reg <= 8'h00;
        end else if (cmd_evt) begin
            last_cmd_reg <= shift_reg;
            if (page_reg == PAGE_DISPLAY && (shift_reg & EXTD_MASK) == EXTD_VAL) begin
                cfg_reg.column_mirror <= shift_reg[2];
                cfg_reg.row_mirror    <= shift_reg[1];
            end else if (page_reg == PAGE_DISPLAY && (shift_reg & SIZE_MASK) == SIZE_VAL) begin
                cfg_reg.bias_current_high <= shift_reg[2];
            end else if (page_reg == PAGE_HVGEN && (shift_reg & HVC_MASK) == HVC_VAL) begin
                cfg_reg.lcd_voltage_range_select <= shift_reg[1];
                cfg_reg.charge_pump_enable       <= shift_reg[0];
            end else if (page_reg == PAGE_HVGEN && (shift_reg & TMP_MASK) == TMP_VAL) begin
                cfg_reg.temp_measure_start <= shift_reg[0];
            end else if (page_reg == PAGE_SPECIAL && (shift_reg & STC_MASK) == STC_VAL) begin
                cfg_reg.display_blank_mode <= shift_reg[1];
                cfg_reg.supply_bypass_mode <= shift_reg[0];
            end else if (page_reg == PAGE_SPECIAL && (shift_reg & OSC_MASK) == OSC_VAL) begin
                cfg_reg.ext_clock_select <= shift_reg[1];
            end else if (page_reg == PAGE_SPECIAL && (shift_reg & COG_MASK) == COG_VAL) begin
                cfg_reg.top_row_swap    <= shift_reg[4];
                cfg_reg.bottom_row_swap <= shift_reg[3];
            end else if ((shift_reg & PAGE_MASK) == PAGE_VAL) begin
                page_reg <= shift_reg[2:0];
            end else if ((shift_reg & FSET_MASK) == FSET_VAL) begin
                cfg_reg.power_down_bit     <= shift_reg[2];
                cfg_reg.vertical_entry_bit <= shift_reg[1];
            end
        end
    end

    // Operating mode priority decode and clock source
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg   <= MODE_PWRDN;
            osc_en_reg <= 1'b1;
        end else begin
            osc_en_reg <= !cfg_reg.ext_clock_select;
            if (cfg_reg.power_down_bit) begin
                mode_reg <= MODE_PWRDN;
            end else if (cfg_reg.display_blank_mode) begin
                mode_reg <= MODE_BLANK;
            end else if (cfg_reg.charge_pump_enable) begin
                mode_reg <= MODE_INTGEN;
            end else if (cfg_reg.supply_bypass_mode) begin
                mode_reg <= MODE_VDDSUP;
            end else begin
                mode_reg <= MODE_EXTSUP;
            end
        end
    end

    // Display RAM write port
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ram_wr_reg   <= 1'b0;
            ram_data_reg <= 8'h00;
            ram_cnt_reg  <= 16'h0000;
        end else begin
            ram_wr_reg <= ram_evt;
            if (ram_evt) begin
                ram_data_reg <= shift_reg;
                ram_cnt_reg  <= ram_cnt_reg + 16'h0001;
            end
        end
    end

    // Bus slave: address phase capture
    assign ahb_take = hsel && htrans[1] && hready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            REG_STATUS_VALUE: rd_mux = {24'h0, status_reg};
            REG_CONFIG_VIEW:  rd_mux = {13'h0, page_reg, mode_reg, cfg_reg};
            REG_LINK_VIEW:    rd_mux = {13'h0, state_reg, ram_data_reg, last_cmd_reg};
            REG_RAM_COUNT:    rd_mux = {16'h0, ram_cnt_reg};
            default:          rd_mux = 32'h0000_0000;
        endcase
        if (ap_valid_reg && ap_write_reg && ap_addr_reg == REG_STATUS_VALUE
            && haddr[7:0] == REG_STATUS_VALUE) begin
            rd_mux = {24'h0, hwdata[7:0]};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
            hrdata_reg   <= 32'h0000_0000;
        end else begin
            ap_valid_reg <= ahb_take;
            if (ahb_take) begin
                ap_write_reg <= hwrite;
                ap_addr_reg  <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
                hrdata_reg   <= (hwrite || haddr[31:8] != 24'h0) ? 32'h0 : rd_mux;
            end
        end
    end

    // Software-written status byte returned on serial reads
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= STATUS_RESET;
        end else if (ap_valid_reg && ap_write_reg && ap_addr_reg == REG_STATUS_VALUE) begin
            status_reg <= hwdata[7:0];
        end
    end

    // Registered outputs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hreadyout                <= 1'b1;
            hresp                    <= 1'b0;
            sda_out                  <= 1'b0;
            serial_data_out_line_out <= 1'b0;
        end else begin
            hreadyout                <= 1'b1;
            hresp                    <= 1'b0;
            sda_out                  <= 1'b0;
            serial_data_out_line_out <= 1'b0; // Open-drain: only the enable toggles
        end
    end

    assign hrdata                   = hrdata_reg;
    assign sda_oe                   = ack_oe_reg;
    assign serial_data_out_line_oe  = serial_data_out_line_oe_reg;
    assign cfg                      = cfg_reg;
    assign op_mode                  = mode_reg;
    assign int_osc_enable           = osc_en_reg;
    assign ram_wr                   = ram_wr_reg;
    assign ram_wr_data              = ram_data_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_data_byte_co;
        state_reg == ST_DATA && byte_end && co_reg;
    endsequence
    sequence s_ack_leave;
        state_reg == ST_ACK && scl_fall && !start_c && !stop_c;
    endsequence

    a_pd_mode: assert property (cfg_reg.power_down_bit |=> mode_reg == MODE_PWRDN)
        else $error("power-down bit did not force power-down mode");
    a_blank_mode: assert property (!cfg_reg.power_down_bit && cfg_reg.display_blank_mode
        |=> mode_reg == MODE_BLANK)
        else $error("blank mode not selected");
    a_intgen_mode: assert property (!cfg_reg.power_down_bit && !cfg_reg.display_blank_mode
        && cfg_reg.charge_pump_enable |=> mode_reg == MODE_INTGEN)
        else $error("internal generator mode not selected");
    a_supply_modes: assert property (!cfg_reg.power_down_bit && !cfg_reg.display_blank_mode
        && !cfg_reg.charge_pump_enable |=> mode_reg == (
        $past(cfg_reg.supply_bypass_mode) ? MODE_VDDSUP : MODE_EXTSUP))
        else $error("supply mode wrong");
    a_osc_select: assert property (int_osc_enable == !$past(cfg_reg.ext_clock_select))
        else $error("oscillator enable does not follow clock select");
    a_start_addr: assert property (start_c |=> state_reg == ST_ADDR && !ack_oe_reg)
        else $error("START did not restart address reception");
    a_ack_hold: assert property (state_reg == ST_ACK && scl_s |-> ack_oe_reg)
        else $error("acknowledge not held during clock high");
    a_addr_ignore: assert property (state_reg == ST_ADDR && byte_end && !addr_match
        && !start_c && !stop_c |=> state_reg == ST_WAIT && !ack_oe_reg)
        else $error("foreign address not ignored");
    a_nack_release: assert property (state_reg == ST_TXACK && scl_rise && sda_s && !stop_c
        |=> state_reg == ST_WAIT && !serial_data_out_line_oe_reg)
        else $error("read not ended on master not-acknowledge");
    a_co_return: assert property (s_data_byte_co && !start_c && !stop_c
        |=> state_reg == ST_ACK && ret_reg == ST_CTRL)
        else $error("control byte not expected after single data byte");
    a_ack_release: assert property (s_ack_leave |=> state_reg != ST_ACK && !ack_oe_reg)
        else $error("acknowledge not released after its clock");
    a_ram_write: assert property (ram_evt && !start_c && !stop_c
        |=> ram_wr_reg && ram_wr_data == $past(shift_reg))
        else $error("display data byte not written");
    a_tx_stable: assert property (state_reg == ST_TX && scl_s && $past(scl_s)
        |-> $stable(serial_data_out_line_oe_reg))
        else $error("read data changed while clock high");
endmodule : ldisc_top

// file: test/ldisc_i2c_master.sv
`timescale 1ns/1ps
// Two-wire bus master model; it only pulls lines low, pull-ups do the rest
module ldisc_i2c_master (
    output logic     scl_low,
    output logic     sda_low,
    input wire logic sda_bus,
    input wire logic dout_bus
);
    localparam time QTR = 20ns; // Quarter of the 80 ns link clock

    // Bus free: clock stands still high, data released
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // START, or repeated START when entered with SCL low
    task automatic start();
        sda_low = 1'b0;
        #QTR scl_low = 1'b0;
        #QTR sda_low = 1'b1;
        #QTR scl_low = 1'b1;
        #QTR;
    endtask : start

    // STOP: SDA rises while SCL is high
    task automatic stop();
        sda_low = 1'b1;
        #QTR scl_low = 1'b0;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask : stop

    // One clock pulse; data changes only while SCL is low
    task automatic clk_bit(input logic b, input logic rd, output logic s);
        sda_low = ~b;
        #QTR scl_low = 1'b0;
        #QTR s = rd ? dout_bus : sda_bus;
        #QTR scl_low = 1'b1;
        #QTR;
    endtask : clk_bit

    // Byte out MSB first, then the acknowledge clock with SDA released
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], 1'b0, s);
        clk_bit(1'b1, 1'b0, s);
        ack = ~s;
    endtask : wbyte

    // Byte in from the data-out line; last byte is not acknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, 1'b1, d[i]);
        clk_bit(last, 1'b0, s);
    endtask : rbyte
endmodule : ldisc_i2c_master

// file: test/ldisc_top_tb.sv
`timescale 1ns/1ps
module ldisc_top_tb;
    import ldisc_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r32;
    logic        hreadyout, hresp, sda_out, sda_oe, dout_out, dout_oe, scl_low, sda_low, ack;
    logic        strap_0 = 1'b0;
    logic        strap_1 = 1'b0;
    logic        ram_wr, int_osc_enable;
    logic [7:0]  ram_wr_data, adr, r8;
    logic [7:0]  d[5];
    logic [7:0]  ram_q[$];
    logic [15:0] rnd;
    ldisc_cfg_t  cfg, exp_cfg;
    ldisc_mode_t op_mode;
    integer      seed = 32'h67d3;
    int          err_count = 0;
    int          tests_run = 0;
    // Open-drain wires with pull-ups
    wire         scl_bus = ~scl_low;
    wire         sda_bus = ~(sda_low | (sda_oe & ~sda_out));
    wire         dout_bus = ~(dout_oe & ~dout_out);

    ldisc_top u_dut (
        .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .scl_in(scl_bus), .sda_in(sda_bus), .sda_out, .sda_oe, .serial_data_out_line_out(dout_out),
        .serial_data_out_line_oe(dout_oe), .address_strap_0(strap_0), .address_strap_1(strap_1), .cfg,
        .op_mode, .int_osc_enable, .ram_wr, .ram_wr_data
    );
    ldisc_i2c_master u_master (.scl_low, .sda_low, .sda_bus, .dout_bus);

    always #4 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // Single AHB-Lite word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Write frame: every byte must be acknowledged
    task automatic send(input logic [7:0] b[$], input logic stop);
        logic a;
        u_master.start();
        foreach (b[i]) begin
            u_master.wbyte(b[i], a);
            chk("ack", 32'h1, {31'h0, a});
        end
        if (stop) u_master.stop();
    endtask : send

    function automatic ldisc_mode_t mode_of(input logic [3:0] k);
        if (k[3]) return MODE_PWRDN;
        if (k[2]) return MODE_BLANK;
        if (k[1]) return MODE_INTGEN;
        return k[0] ? MODE_VDDSUP : MODE_EXTSUP;
    endfunction : mode_of

    // Each RAM write pulse takes the oldest expected byte
    always @(posedge mclk) begin
        if (ram_wr === 1'b1) begin
            if (ram_q.size() == 0) chk("ram_wr extra", 32'h0, 32'h1);
            else chk("ram_wr_data", {24'h0, ram_q.pop_front()}, {24'h0, ram_wr_data});
        end
    end

    initial begin
        #400000;
        err_count++;
        stop_test();
    end

    initial begin
        rnd = 16'($random(seed));
        strap_0 <= rnd[0];
        strap_1 <= rnd[1];
        adr = {SLAVE_ADDR_HI, rnd[1:0], 1'b0};
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        chk("cfg reset", {19'h0, CFG_RESET}, {19'h0, cfg});
        chk("osc reset", 32'h1, {31'h0, int_osc_enable});
        chk("hresp", 32'h0, {31'h0, hresp});
        ahb(1'b0, {24'h0, REG_CONFIG_VIEW}, 32'h0, r32);
        chk("config view", {13'h0, 3'h0, MODE_PWRDN, CFG_RESET}, r32);
        ahb(1'b0, 32'h10, 32'h0, r32);
        chk("unmapped", 32'h0, r32);
        repeat (4) @(posedge mclk);
        // Neighbouring strap address must be ignored
        u_master.start();
        u_master.wbyte(adr ^ 8'h02, ack);
        chk("foreign ack", 32'h0, {31'h0, ack});
        u_master.stop();
        // Every priority combination, other flags random
        for (int k = 0; k < 16; k++) begin
            rnd = 16'($random(seed));
            exp_cfg = {k[3], rnd[0], k[1], rnd[1], rnd[2], rnd[3], rnd[4], rnd[5], rnd[6], rnd[7], k[0], k[2], rnd[8]};
            send('{adr, 8'h00, 8'h0b, {6'h01, k[2], k[0]}, {6'h02, rnd[7], 1'b0}, {3'h2, rnd[5], rnd[6], 3'h0},
                8'h0e, {5'h01, rnd[3], rnd[4], 1'b0}, {5'h04, rnd[8], 2'h0}, 8'h0d, {6'h01, rnd[1], k[1]},
                {7'h10, rnd[2]}, 8'h08, {5'h02, k[3], rnd[0], 1'b0}}, 1'b1);
            chk("cfg", {19'h0, exp_cfg}, {19'h0, cfg});
            chk("op_mode", {29'h0, mode_of(k[3:0])}, {29'h0, op_mode});
            chk("int_osc", {31'h0, ~rnd[7]}, {31'h0, int_osc_enable});
        end
        ahb(1'b0, {24'h0, REG_CONFIG_VIEW}, 32'h0, r32);
        chk("config view", {13'h0, 3'h0, MODE_PWRDN, exp_cfg}, r32);
        // RAM bytes: single with continuation, stream, repeated START
        rnd = 16'($random(seed));
        d = '{rnd[7:0], rnd[15:8], ~rnd[7:0], 8'h5a ^ rnd[15:8], 8'ha5};
        foreach (d[i]) ram_q.push_back(d[i]);
        send('{adr, 8'hc0, d[0], 8'h40, d[1], d[2]}, 1'b0);
        send('{adr, 8'h40, d[3], d[4]}, 1'b1);
        chk("ram left", 32'h0, ram_q.size());
        // Status read: two bytes, the last one not acknowledged
        ahb(1'b1, {24'h0, REG_STATUS_VALUE}, {24'h0, rnd[15:8]}, r32);
        ahb(1'b0, {24'h0, REG_STATUS_VALUE}, 32'h0, r32);
        chk("status", {24'h0, rnd[15:8]}, r32);
        u_master.start();
        u_master.wbyte(adr | 8'h01, ack);
        chk("read ack", 32'h1, {31'h0, ack});
        u_master.rbyte(1'b0, r8);
        chk("read 1", {24'h0, rnd[15:8]}, {24'h0, r8});
        u_master.rbyte(1'b1, r8);
        chk("read 2", {24'h0, rnd[15:8]}, {24'h0, r8});
        u_master.stop();
        chk("dout released", 32'h1, {31'h0, dout_bus});
        chk("sda released", 32'h1, {31'h0, sda_bus});
        stop_test();
    end
endmodule : ldisc_top_tb
